// File: verilog/prt_pkg.sv
package prt_pkg;

  localparam int NPORT = 6;
  localparam int NPIN  = 16;
  localparam int NPAD  = 96;
  localparam int NSIG  = 22;
  localparam int NFN   = 8;
  localparam int NLOC  = 7;
  localparam int NSER  = 2;
  localparam int LOCW  = 3;
  localparam int PADW  = 7;
  localparam int SIGW  = 5;
  localparam int PORTW = 3;
  localparam int MODEW = 3;
  localparam int NHOST = 3;

  // Signal slots inside one serial unit: 2 is CLK or CTS, 3 is CS or RTS
  localparam int SER_SIGS  = 4;
  localparam int SER_HS_A  = 2;
  localparam int SER_HS_B  = 3;

  // Pin numbers kept away from external interrupts
  localparam int PIN_IRQ_RSVD  = 0;
  localparam int PIN_NOT_AVAIL = 8;
  localparam int IRQ_MAX       = 14;

  localparam logic [PADW-1:0] PAD_NONE = 7'h7f;

  // Pad index is port * 16 + pin; ports A..F are 0..5
  localparam logic [127:0] PAD_EXIST =
    128'h0000_0000_0c07_fc07_00ff_e203_1800_0044;

  typedef enum logic [MODEW-1:0] {
    MODE_DIS, MODE_IN_PU, MODE_IN_PD, MODE_IN_PU_FLT, MODE_IN_PD_FLT,
    MODE_OUT
  } prt_mode_t;

  typedef enum logic [1:0] {HOST_UART, HOST_SPI, HOST_USB} prt_host_t;

  localparam prt_host_t   HOST_RST     = HOST_UART;
  localparam logic [NHOST-1:0] HOST_RST_HOT = 3'h1;
  localparam logic [LOCW-1:0]  LOC_RST      = 3'h0;
  localparam logic [PORTW-1:0] PORT_RST     = 3'h0;

  // Owning function of each signal
  localparam logic [2:0] FN_OF [NSIG] = '{
    3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1,
    3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4,
    3'h5, 3'h5, 3'h5, 3'h6, 3'h6, 3'h6, 3'h7, 3'h7};

  localparam logic [PADW-1:0] N = PAD_NONE;

  // Pad per signal and location 0..6
  localparam logic [PADW-1:0] ROUTE_TBL [NSIG][NLOC] = '{
    '{7'h4a, N, N, 7'h4d, N, 7'h20, N},         // ser0 tx/mosi
    '{7'h4b, N, N, 7'h4c, N, 7'h21, N},         // ser0 rx/miso
    '{7'h4c, N, 7'h29, 7'h2f, N, N, N},         // ser0 cts/clk
    '{7'h4d, N, N, 7'h2e, N, N, N},             // ser0 rts/cs
    '{7'h20, 7'h30, 7'h37, N, N, N, N},         // ser1 tx/mosi
    '{7'h21, 7'h31, 7'h36, N, N, N, N},         // ser1 rx/miso
    '{N, 7'h32, 7'h50, N, N, N, N},             // ser1 cts/clk
    '{N, 7'h33, 7'h51, N, N, N, N},             // ser1 rts/cs
    '{N, 7'h37, N, N, 7'h21, 7'h51, 7'h4d},     // i2c0 scl
    '{N, 7'h36, N, N, 7'h20, 7'h50, 7'h4c},     // i2c0 sda
    '{N, 7'h1c, 7'h41, N, N, N, N},             // i2c1 scl
    '{N, 7'h1b, 7'h40, N, N, N, N},             // i2c1 sda
    '{7'h5a, N, N, N, N, N, N},                 // usb dm
    '{7'h5b, N, N, N, N, N, N},                 // usb dp
    '{N, N, N, 7'h31, N, 7'h50, N},             // tim0 cc0
    '{N, N, N, 7'h32, 7'h20, 7'h51, N},         // tim0 cc1
    '{7'h02, 7'h02, N, 7'h33, 7'h21, 7'h52, N}, // tim0 cc2
    '{7'h2d, 7'h4a, N, N, 7'h36, N, N},         // tim1 cc0
    '{7'h2e, 7'h4b, N, N, 7'h37, N, N},         // tim1 cc1
    '{7'h2f, 7'h4c, N, 7'h1b, 7'h2d, N, N},     // tim1 cc2
    '{7'h50, 7'h50, 7'h50, 7'h50, N, N, N},     // debug clock
    '{7'h51, 7'h51, 7'h51, 7'h51, N, N, N}};    // debug data

endpackage : prt_pkg

// File: verilog/prt_pad_router.sv
// How it works
// - Each function's signals share one location.
// - Locations loaded once from configuration, then locked.
// - First serial UART location five: no handshake.
// - Second serial UART location zero: no handshake.
// - Pad modes: pulled input, filtered, output, disabled.
// - Reset leaves every pad disabled.
// - Any existing pad except bits zero and eight may interrupt; fourteen lines at most.
// - Same bit number shares one interrupt line.
// - Bit zero never used as interrupt.
// - Bit eight unavailable everywhere.
// - Exactly one host interface selected.
// - Factory default host interface is UART.
module prt_pad_router
  import prt_pkg::*;
#(
  parameter int IRQ_LIMIT = IRQ_MAX
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   reset_in,
  input  wire logic                   cfg_load_in,
  input  wire logic [NFN-1:0]         cfg_fn_en_in,
  input  wire logic [NFN*LOCW-1:0]    cfg_loc_in,
  input  wire logic [NSER-1:0]        cfg_ser_uart_in,
  input  wire logic [1:0]             cfg_host_in,
  input  wire logic                   mode_we_in,
  input  wire logic [NPAD*MODEW-1:0]  mode_in,
  input  wire logic                   irq_we_in,
  input  wire logic [NPIN*PORTW-1:0]  irq_port_in,
  input  wire logic [NPIN-1:0]        irq_en_in,
  input  wire logic [NPIN-1:0]        irq_rise_in,
  input  wire logic [NPIN-1:0]        irq_fall_in,
  input  wire logic [NPIN-1:0]        irq_clr_in,
  input  wire logic [NSIG-1:0]        fn_out_in,
  input  wire logic [NSIG-1:0]        fn_oe_in,
  input  wire logic [NPAD-1:0]        gpio_out_in,
  input  wire logic [NPAD-1:0]        pad_rx_in,
  output logic      [NSIG-1:0]        fn_in_out,
  output logic      [NPAD-1:0]        gpio_in_out,
  output logic      [NPAD-1:0]        pad_tx_out,
  output logic      [NPAD-1:0]        pad_oe_out,
  output logic      [NPAD-1:0]        pad_ie_out,
  output logic      [NPAD-1:0]        pad_pu_out,
  output logic      [NPAD-1:0]        pad_pd_out,
  output logic      [NPAD-1:0]        pad_filt_out,
  output logic      [NPIN-1:0]        irq_pend_out,
  output logic                        cfg_locked_out,
  output logic                        cfg_err_out,
  output logic      [NHOST-1:0]       host_sel_out,
  output logic      [NSER-1:0]        ser_hs_out
);

  if (IRQ_LIMIT != NPIN - 2 || NPAD != NPORT * NPIN) begin : g_chk
    $error("prt_pad_router: unsupported parameter values");
  end

  // Pad input synchronisers and two-sample glitch filter
  logic [NPAD-1:0] sync1_r;
  logic [NPAD-1:0] sync2_r;
  logic [NPAD-1:0] sync3_r;
  logic [NPAD-1:0] filt_r;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      filt_r  <= '0;
    end else begin
      sync1_r <= pad_rx_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r  <= (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));
    end
  end

  // Configuration: taken once, checked before it is accepted
  logic [NFN-1:0]      fn_en_r;
  logic [NFN*LOCW-1:0] loc_r;
  logic [NSER-1:0]     uart_r;
  prt_host_t           host_r;
  logic [NFN-1:0]      fn_hit;
  logic [NFN-1:0]      fn_bad;
  logic                host_bad;
  logic                cfg_ok;
  logic                cfg_take;

  always_comb begin
    fn_hit = '0;
    for (int s = 0; s < NSIG; s++) begin
      for (int l = 0; l < NLOC; l++) begin
        if (cfg_loc_in[FN_OF[s]*LOCW +: LOCW] == LOCW'(l) &&
            ROUTE_TBL[s][l] != PAD_NONE) begin
          fn_hit[FN_OF[s]] = 1'b1;
        end
      end
    end
  end

  assign fn_bad   = cfg_fn_en_in & ~fn_hit;
  assign host_bad = cfg_host_in > 2'(HOST_USB);
  assign cfg_ok   = ~|fn_bad && !host_bad;
  assign cfg_take = cfg_load_in && !cfg_locked_out && cfg_ok;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fn_en_r        <= '0;
      loc_r          <= {NFN{LOC_RST}};
      uart_r         <= '0;
      host_r         <= HOST_RST;
      cfg_locked_out <= 1'b0;
      cfg_err_out    <= 1'b0;
    end else if (cfg_load_in && !cfg_locked_out) begin
      cfg_err_out <= !cfg_ok;
      if (cfg_take) begin
        fn_en_r        <= cfg_fn_en_in;
        loc_r          <= cfg_loc_in;
        uart_r         <= cfg_ser_uart_in;
        host_r         <= prt_host_t'(cfg_host_in);
        cfg_locked_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      host_sel_out <= HOST_RST_HOT;
    end else begin
      host_sel_out <= NHOST'(1) << host_r;
    end
  end

  // Signal to pad routing
  logic [PADW-1:0] sig_raw [NSIG];
  logic [PADW-1:0] sig_pad [NSIG];
  logic [NSER-1:0] hs_ok;

  for (genvar s = 0; s < NSIG; s++) begin : g_sig
    wire [LOCW-1:0] lc = loc_r[FN_OF[s]*LOCW +: LOCW];
    wire            on = fn_en_r[FN_OF[s]] && lc < LOCW'(NLOC);
    assign sig_raw[s] = on ? ROUTE_TBL[s][lc] : PAD_NONE;
    if (s < NSER * SER_SIGS && s % SER_SIGS >= SER_HS_A) begin : g_hs
      // Handshake pins dropped when the UART location lacks them
      wire strip = uart_r[s / SER_SIGS] &&
                   !hs_ok[s / SER_SIGS];
      assign sig_pad[s] = strip ? PAD_NONE : sig_raw[s];
    end else begin : g_plain
      assign sig_pad[s] = sig_raw[s];
    end
  end

  for (genvar u = 0; u < NSER; u++) begin : g_ser
    assign hs_ok[u] = sig_raw[u*SER_SIGS+SER_HS_A] != PAD_NONE &&
                      sig_raw[u*SER_SIGS+SER_HS_B] != PAD_NONE;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ser_hs_out <= '0;
    end else begin
      ser_hs_out <= uart_r & fn_en_r[NSER-1:0] & hs_ok;
    end
  end

  // Pad ownership: lowest signal number wins a shared pad
  logic [NPAD-1:0] own_hit;
  logic [SIGW-1:0] own_sig [NPAD];

  always_comb begin
    for (int p = 0; p < NPAD; p++) begin
      own_hit[p] = 1'b0;
      own_sig[p] = '0;
      for (int s = NSIG - 1; s >= 0; s--) begin
        if (sig_pad[s] == PADW'(p)) begin
          own_hit[p] = 1'b1;
          own_sig[p] = SIGW'(s);
        end
      end
    end
  end

  // Per pad mode and drive
  prt_mode_t       mode_r [NPAD];
  logic [NPAD-1:0] oe_nxt;
  logic [NPAD-1:0] tx_nxt;
  logic [NPAD-1:0] ie_nxt;
  logic [NPAD-1:0] pu_nxt;
  logic [NPAD-1:0] pd_nxt;
  logic [NPAD-1:0] flt_nxt;
  logic [NPAD-1:0] val;

  for (genvar p = 0; p < NPAD; p++) begin : g_pad
    wire [MODEW-1:0] code = mode_in[p*MODEW +: MODEW];
    wire prt_mode_t  wmode = code > MODEW'(MODE_OUT) ? MODE_DIS :
                             prt_mode_t'(code);
    wire prt_mode_t  md = mode_r[p];
    wire is_out = md == MODE_OUT;
    wire is_pu  = md == MODE_IN_PU || md == MODE_IN_PU_FLT;
    wire is_pd  = md == MODE_IN_PD || md == MODE_IN_PD_FLT;
    wire is_flt = md == MODE_IN_PU_FLT || md == MODE_IN_PD_FLT;
    wire ex     = PAD_EXIST[p];

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
        mode_r[p] <= MODE_DIS;
      end else if (mode_we_in && ex) begin
        mode_r[p] <= wmode;
      end
    end

    assign oe_nxt[p]  = ex && (own_hit[p] ? fn_oe_in[own_sig[p]] : is_out);
    assign tx_nxt[p]  = oe_nxt[p] &&
                        (own_hit[p] ? fn_out_in[own_sig[p]] : gpio_out_in[p]);
    assign ie_nxt[p]  = ex && (own_hit[p] || is_pu || is_pd);
    assign pu_nxt[p]  = ex && is_pu;
    assign pd_nxt[p]  = ex && is_pd;
    assign flt_nxt[p] = ex && is_flt;
    assign val[p]     = ie_nxt[p] && (is_flt ? filt_r[p] : sync2_r[p]);
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pad_tx_out   <= '0;
      pad_oe_out   <= '0;
      pad_ie_out   <= '0;
      pad_pu_out   <= '0;
      pad_pd_out   <= '0;
      pad_filt_out <= '0;
      gpio_in_out  <= '0;
    end else begin
      pad_tx_out   <= tx_nxt;
      pad_oe_out   <= oe_nxt;
      pad_ie_out   <= ie_nxt;
      pad_pu_out   <= pu_nxt;
      pad_pd_out   <= pd_nxt;
      pad_filt_out <= flt_nxt;
      gpio_in_out  <= val;
    end
  end

  // Peripheral inputs from their routed pads
  logic [127:0]    val_ext;
  logic [NSIG-1:0] fin_nxt;

  assign val_ext = 128'(val);

  for (genvar s = 0; s < NSIG; s++) begin : g_fin
    assign fin_nxt[s] = sig_pad[s] != PAD_NONE && val_ext[sig_pad[s]];
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fn_in_out <= '0;
    end else begin
      fn_in_out <= fin_nxt;
    end
  end

  // External pin interrupts, one line per bit number
  logic [NPIN*PORTW-1:0] irq_port_r;
  logic [NPIN-1:0]       irq_en_r;
  logic [NPIN-1:0]       irq_rise_r;
  logic [NPIN-1:0]       irq_fall_r;
  logic [NPIN-1:0]       irq_prev_r;
  logic [NPIN-1:0]       irq_src;
  logic [NPIN-1:0]       irq_hit;
  logic [127:0]          sync_ext;

  assign sync_ext = 128'(sync2_r);

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_port_r <= {NPIN{PORT_RST}};
      irq_en_r   <= '0;
      irq_rise_r <= '0;
      irq_fall_r <= '0;
    end else if (irq_we_in) begin
      irq_port_r <= irq_port_in;
      irq_en_r   <= irq_en_in;
      irq_rise_r <= irq_rise_in;
      irq_fall_r <= irq_fall_in;
    end
  end

  for (genvar b = 0; b < NPIN; b++) begin : g_irq
    wire [PORTW-1:0] sel = irq_port_r[b*PORTW +: PORTW];
    wire [PADW-1:0]  idx = {sel, 4'(b)};
    wire usable = b != PIN_IRQ_RSVD && b != PIN_NOT_AVAIL;
    wire on = usable && irq_en_r[b] && PAD_EXIST[idx];
    assign irq_src[b] = on && sync_ext[idx];
    assign irq_hit[b] = on &&
      ((irq_rise_r[b] && irq_src[b] && !irq_prev_r[b]) ||
       (irq_fall_r[b] && !irq_src[b] && irq_prev_r[b]));
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_prev_r   <= '0;
      irq_pend_out <= '0;
    end else begin
      irq_prev_r   <= irq_src;
      irq_pend_out <= irq_hit | (irq_pend_out & ~irq_clr_in);
    end
  end

endmodule : prt_pad_router

// File: tb/prt_pad_router_properties.sv
module prt_pad_router_properties
  import prt_pkg::*;
#(
  parameter int IRQ_LIMIT = IRQ_MAX
) (
  input wire logic                sys_clk_in,
  input wire logic                reset_in,
  input wire logic                cfg_load_in,
  input wire logic [NFN-1:0]      cfg_fn_en_in,
  input wire logic [NFN*LOCW-1:0] cfg_loc_in,
  input wire logic [NSER-1:0]     cfg_ser_uart_in,
  input wire logic [1:0]          cfg_host_in,
  input wire logic [NPIN-1:0]     irq_clr_in,
  input wire logic [NPAD-1:0]     pad_tx_out,
  input wire logic [NPAD-1:0]     pad_oe_out,
  input wire logic [NPAD-1:0]     pad_ie_out,
  input wire logic [NPAD-1:0]     pad_pu_out,
  input wire logic [NPAD-1:0]     pad_pd_out,
  input wire logic [NPIN-1:0]     irq_pend_out,
  input wire logic                cfg_locked_out,
  input wire logic                cfg_err_out,
  input wire logic [NHOST-1:0]    host_sel_out,
  input wire logic [NSER-1:0]     ser_hs_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  wire take = cfg_load_in && !cfg_locked_out;

  rst_idle_a: assert property ($fell(reset_in) |->
    pad_oe_out == '0 && pad_ie_out == '0 && host_sel_out == HOST_RST_HOT)
    else $error("pads active after reset");
  lock_take_a: assert property (take |=>
    cfg_locked_out != cfg_err_out) else $error("load gave no answer");
  lock_hold_a: assert property (cfg_locked_out ##1 cfg_locked_out
    |=> cfg_locked_out && $stable(host_sel_out))
    else $error("locked routing changed");
  bad_loc_a: assert property (take && cfg_fn_en_in[0] &&
    cfg_loc_in[2:0] == 3'h7 |=> cfg_err_out && !cfg_locked_out)
    else $error("empty location accepted");
  host_one_a: assert property (take ##1 cfg_locked_out |=>
    host_sel_out == (3'h1 << $past(cfg_host_in, 2)))
    else $error("host select wrong");
  ser0_nohs_a: assert property (take && cfg_ser_uart_in[0] &&
    cfg_loc_in[2:0] == 3'h5 ##1 cfg_locked_out |-> !ser_hs_out[0] [*3])
    else $error("first serial handshake on");
  ser1_nohs_a: assert property (take && cfg_ser_uart_in[1] &&
    cfg_loc_in[5:3] == 3'h0 ##1 cfg_locked_out |-> !ser_hs_out[1] [*3])
    else $error("second serial handshake on");
  pad_gate_a: assert property ((pad_tx_out & ~pad_oe_out) == '0 &&
    (pad_pu_out & pad_pd_out) == '0) else $error("pad control clash");
  irq_rsvd_a: assert property (!irq_pend_out[PIN_IRQ_RSVD] &&
    !irq_pend_out[PIN_NOT_AVAIL] && $countones(irq_pend_out) <= IRQ_LIMIT)
    else $error("reserved interrupt line pending");
  irq_stick_a: assert property (($past(irq_pend_out) &
    ~$past(irq_clr_in) & ~irq_pend_out) == '0)
    else $error("pending dropped without clear");

  cover property (take ##1 cfg_locked_out);
  cover property (take ##1 cfg_err_out);
  cover property ($rose(irq_pend_out[11]));
  cover property ($rose(ser_hs_out[0]));
endmodule : prt_pad_router_properties

// File: tb/prt_pad_peer.sv
module prt_pad_peer
  import prt_pkg::*;
(
  input  wire logic            sys_clk_in,
  input  wire logic [NPAD-1:0] pad_tx_in,
  input  wire logic [NPAD-1:0] pad_oe_in,
  input  wire logic [NPAD-1:0] pad_pu_in,
  input  wire logic [NPAD-1:0] pad_pd_in,
  input  wire logic [NPAD-1:0] ext_en_in,
  input  wire logic [NPAD-1:0] ext_val_in,
  output logic      [NPAD-1:0] pad_lvl_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Host link kept under this rate, flow control on
  localparam int UART_BPS_LIM = 1000000;
  logic flip_r = 1'b0;
  always_ff @(posedge sys_clk_in) flip_r <= ~flip_r;
  // Undriven, unpulled pads toggle so stale data never reads as valid
  assign pad_lvl_out = (pad_oe_in & pad_tx_in) |
    (~pad_oe_in & ext_en_in & ext_val_in) |
    (~pad_oe_in & ~ext_en_in & (pad_pu_in | (~pad_pd_in & {NPAD{flip_r}})));
endmodule : prt_pad_peer

// File: tb/prt_pad_router_tb.sv
module prt_pad_router_tb;
  import prt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 0, reset_in = 1, cfg_load_in = 0, mode_we_in = 0;
  logic irq_we_in = 0;
  logic [NFN-1:0] cfg_fn_en_in = '0;
  logic [NFN*LOCW-1:0] cfg_loc_in = '0;
  logic [1:0] cfg_ser_uart_in = '0, cfg_host_in = '0;
  logic [NPAD*MODEW-1:0] mode_in = '0;
  logic [NPIN*PORTW-1:0] irq_port_in = '0;
  logic [NPIN-1:0] irq_en_in = '0, irq_clr_in = '0;
  logic [NPIN-1:0] irq_rise_in = '1, irq_fall_in = '0;
  logic [NSIG-1:0] fn_out_in = '0, fn_oe_in = '0;
  logic [NPAD-1:0] gpio_out_in = '0, ext_en = '0, ext_val = '0;
  wire [NSIG-1:0] fn_in_out;
  wire [NPAD-1:0] gpio_in_out, pad_tx_out, pad_oe_out, pad_ie_out, pad_rx_in;
  wire [NPAD-1:0] pad_pu_out, pad_pd_out, pad_filt_out;
  wire [NPIN-1:0] irq_pend_out;
  wire cfg_locked_out, cfg_err_out;
  wire [NHOST-1:0] host_sel_out;
  wire [NSER-1:0] ser_hs_out;
  int failures = 0, checked = 0, cycles = 0;

  prt_pad_router #(.IRQ_LIMIT(IRQ_MAX)) dut (.sys_clk_in, .reset_in,
    .cfg_load_in, .cfg_fn_en_in, .cfg_loc_in, .cfg_ser_uart_in, .cfg_host_in,
    .mode_we_in, .mode_in, .irq_we_in, .irq_port_in, .irq_en_in, .irq_rise_in,
    .irq_fall_in, .irq_clr_in, .fn_out_in, .fn_oe_in, .gpio_out_in,
    .pad_rx_in, .fn_in_out, .gpio_in_out, .pad_tx_out, .pad_oe_out,
    .pad_ie_out, .pad_pu_out, .pad_pd_out, .pad_filt_out, .irq_pend_out,
    .cfg_locked_out, .cfg_err_out, .host_sel_out, .ser_hs_out);
  prt_pad_peer peer (.sys_clk_in, .pad_tx_in(pad_tx_out),
    .pad_oe_in(pad_oe_out), .pad_pu_in(pad_pu_out), .pad_pd_in(pad_pd_out),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_lvl_out(pad_rx_in));

  always #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      complete_run;
    end
  end

  task chk(input logic [95:0] seen, input logic [95:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : cyc

  task t_reset;
    chk(pad_oe_out, '0, "pad_oe");
    chk(pad_ie_out, '0, "pad_ie");
    chk(96'(host_sel_out), 96'h1, "host_sel");
    $display("test reset done");
  endtask : t_reset

  task t_cfg;
    cfg_fn_en_in = 8'h03;
    cfg_ser_uart_in = 2'h3;
    cfg_host_in = 2'h1;
    cfg_loc_in = 24'h7;
    cfg_load_in = 1;
    cyc(1);
    cfg_load_in = 0;
    cyc(2);
    chk(96'({cfg_locked_out, cfg_err_out}), 96'h1, "reject");
    cfg_loc_in = 24'h5;
    cfg_load_in = 1;
    cyc(1);
    cfg_load_in = 0;
    cyc(2);
    chk(96'({cfg_locked_out, cfg_err_out}), 96'h2, "accept");
    chk(96'(host_sel_out), 96'h2, "host_sel");
    chk(96'(ser_hs_out), 96'h0, "handshake");
    fn_oe_in = 22'h1;
    fn_out_in = 22'h1;
    ext_en[33] = 1;
    ext_val[33] = 1;
    cyc(5);
    chk(pad_oe_out, 96'h1 << 32, "pad_oe");
    chk(pad_tx_out, 96'h1 << 32, "pad_tx");
    chk(96'(fn_in_out[3:1]), 96'h1, "rx and cts");
    cfg_host_in = 2'h2;
    cfg_load_in = 1;
    cyc(1);
    cfg_load_in = 0;
    cyc(3);
    chk(96'(host_sel_out), 96'h2, "locked host");
    $display("test config done");
  endtask : t_cfg

  task t_mode;
    for (int m = 0; m < 6; m++) mode_in[3*(48+m) +: 3] = 3'(m);
    gpio_out_in[53] = 1;
    mode_we_in = 1;
    cyc(1);
    mode_we_in = 0;
    cyc(2);
    chk(96'(pad_oe_out[53:48]), 96'h20, "out mode");
    chk(96'(pad_tx_out[53:48]), 96'h20, "out value");
    chk(96'(pad_ie_out[53:48]), 96'h1e, "in mode");
    chk(96'(pad_pu_out[53:48]), 96'h0a, "pull up");
    chk(96'(pad_pd_out[53:48]), 96'h14, "pull down");
    chk(96'(pad_filt_out[53:48]), 96'h18, "filter");
    cyc(4);
    chk(96'(gpio_in_out[53:48]), 96'h0a, "pad input");
    $display("test modes done");
  endtask : t_mode

  task t_irq;
    ext_en[27] = 1;
    ext_en[75] = 1;
    ext_en[48] = 1;
    mode_in = {NPAD{3'h2}};
    mode_we_in = 1;
    cyc(1);
    mode_we_in = 0;
    irq_port_in[33 +: 3] = 3'h1;
    irq_port_in[2:0] = 3'h3;
    irq_en_in = 16'h0901;
    irq_we_in = 1;
    cyc(1);
    irq_we_in = 0;
    cyc(4);
    irq_clr_in = '1;
    cyc(1);
    irq_clr_in = '0;
    ext_val[75] = 1;
    ext_val[48] = 1;
    cyc(6);
    chk(96'(irq_pend_out), '0, "other port, pin zero");
    ext_val[27] = 1;
    cyc(6);
    ext_val[27] = 0;
    cyc(6);
    chk(96'(irq_pend_out), 96'h800, "pin eleven");
    irq_clr_in[11] = 1;
    cyc(1);
    irq_clr_in = '0;
    cyc(1);
    chk(96'(irq_pend_out), '0, "cleared");
    irq_rise_in = '0;
    irq_fall_in = 16'h0800;
    irq_we_in = 1;
    ext_val[27] = 1;
    cyc(1);
    irq_we_in = 0;
    cyc(6);
    chk(96'(irq_pend_out), '0, "rise masked");
    ext_val[27] = 0;
    irq_clr_in[11] = 1;
    cyc(3);
    chk(96'(irq_pend_out), 96'h800, "set over clear");
    irq_clr_in = '0;
    $display("test interrupts done");
  endtask : t_irq

  task t_relock;
    reset_in = 1;
    cyc(2);
    chk(pad_oe_out, '0, "reset pads");
    chk(96'(irq_pend_out), '0, "reset pending");
    reset_in = 0;
    cyc(1);
    chk(96'(host_sel_out), 96'h1, "reset host");
    cfg_fn_en_in = 8'h01;
    cfg_ser_uart_in = 2'h1;
    cfg_loc_in = 24'h0;
    cfg_host_in = 2'h2;
    cfg_load_in = 1;
    cyc(1);
    cfg_load_in = 0;
    cyc(2);
    chk(96'(ser_hs_out), 96'h1, "handshake kept");
    chk(96'(host_sel_out), 96'h4, "host usb");
    chk(pad_oe_out, 96'h1 << 74, "relocated tx");
    $display("test relock done");
  endtask : t_relock

  task complete_run;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  initial begin
    cyc(8);
    reset_in = 0;
    cyc(1);
    t_reset;
    t_cfg;
    t_mode;
    t_irq;
    t_relock;
    complete_run;
  end
endmodule : prt_pad_router_tb

bind prt_pad_router prt_pad_router_properties #(.IRQ_LIMIT(IRQ_LIMIT)) u_props
  (.sys_clk_in, .reset_in, .cfg_load_in, .cfg_fn_en_in, .cfg_loc_in,
   .cfg_ser_uart_in, .cfg_host_in, .irq_clr_in, .pad_tx_out, .pad_oe_out,
   .pad_ie_out, .pad_pu_out, .pad_pd_out, .irq_pend_out, .cfg_locked_out,
   .cfg_err_out, .host_sel_out, .ser_hs_out);
